/* design/cmd_unit_pkg.sv */
// constants, frame layout and carrier types of the command unit
// assumes one clock and byte-wide frame delivery from a transport outside
package cmd_unit_pkg;
  localparam logic [7:0] OP_HOME = 8'h0D;
  localparam logic [7:0] OP_SET_OUT = 8'h0E;
  localparam logic [7:0] OP_READ = 8'h0F;
  localparam logic [7:0] HOME_START = 8'h00;
  localparam logic [7:0] HOME_STOP = 8'h01;
  localparam logic [7:0] HOME_STATUS = 8'h02;
  localparam logic [7:0] BANK_DIN = 8'h00;
  localparam logic [7:0] BANK_AIN = 8'h01;
  localparam logic [7:0] BANK_OUT = 8'h02;
  localparam logic [7:0] PORT_ALL = 8'hFF;
  localparam logic [7:0] STATUS_OK = 8'h64;
  localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
  localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
  localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
  localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
  localparam logic [7:0] HOST_ADDR_RST = 8'h02;
  localparam logic [7:0] MODULE_ADDR_RST = 8'h01;
  localparam logic [31:0] VALUE_FROM_ACC = 32'hFFFFFFFF;
  localparam logic [31:0] ACC_RST = 32'h00000000;
  localparam logic [3:0] FRAME_LAST = 4'h8;
  localparam logic [3:0] IDX_TARGET = 4'h0;
  localparam logic [3:0] IDX_CODE = 4'h1;
  localparam logic [3:0] IDX_TYPE = 4'h2;
  localparam logic [3:0] IDX_BANK = 4'h3;

  // one decoded command frame
  typedef struct packed {
    logic [7:0] target;
    logic [7:0] code;
    logic [7:0] kind;
    logic [7:0] bank;
    logic [31:0] value;
  } cmd_t;

  // reply byte stream output
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_out_t;

  typedef enum logic [1:0] {
    ST_RECV = 2'b00,
    ST_EXEC = 2'b01,
    ST_SEND = 2'b11
  } state_t;
endpackage : cmd_unit_pkg

/* design/refsearch_io_command_unit.sv */
// command interpreter: home search, output setting and port reads
// assumes bytes arrive one per cycle with a valid strobe, already framed
`timescale 1ns/100ps
module refsearch_io_command_unit #(
  parameter int AXES = 6,
  parameter int AIN_W = 16
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic STANDALONE,
  input wire logic [3:0] GP_INPUT,
  input wire logic [4*AIN_W-1:0] ANALOG_IN,
  input wire logic [AXES-1:0] HOME_DONE,
  output logic TX_VALID,
  output logic [7:0] TX_BYTE,
  output logic [3:0] GP_OUTPUT,
  output logic [AXES-1:0] HOME_START_PULSE,
  output logic [AXES-1:0] HOME_STOP_PULSE,
  output logic [AXES-1:0] HOME_BUSY,
  output logic [31:0] ACCUMULATOR
);
  cmd_unit_pkg::state_t state_reg, state_next;
  logic [3:0] idx_reg;
  logic [7:0] sum_reg;
  logic [7:0] frame_reg [0:7];
  logic [7:0] reply_reg [0:7];
  logic [7:0] tx_sum_reg;
  logic [AXES-1:0] busy_reg;
  logic [AXES-1:0] start_reg;
  logic [AXES-1:0] stop_reg;
  logic [3:0] out_reg;
  logic [31:0] acc_reg;
  cmd_unit_pkg::byte_out_t tx_reg;

  // assembled command, value most significant byte first
  cmd_unit_pkg::cmd_t cmd;
  assign cmd = {frame_reg[0], frame_reg[1], frame_reg[2], frame_reg[3],
                frame_reg[4], frame_reg[5], frame_reg[6], frame_reg[7]};

  // ninth byte of a frame is the checksum; no address filtering is done
  wire last_byte = RX_VALID && (idx_reg == cmd_unit_pkg::FRAME_LAST);
  // checksum verdict is latched with the ninth byte: the receive line may
  // move again during execute, so it cannot be compared there
  wire sum_match = (sum_reg == RX_BYTE);
  logic sum_ok_reg;
  wire is_home = (cmd.code == cmd_unit_pkg::OP_HOME);
  wire is_set = (cmd.code == cmd_unit_pkg::OP_SET_OUT);
  wire is_read = (cmd.code == cmd_unit_pkg::OP_READ);
  wire axis_ok = (cmd.bank < 8'(AXES));
  wire [2:0] axis = cmd.bank[2:0];
  wire port_ok = (cmd.kind < 8'h04);
  wire [1:0] port = cmd.kind[1:0];
  wire all_port = (cmd.kind == cmd_unit_pkg::PORT_ALL);

  // set source: accumulator when value is -1
  wire [31:0] set_src = (cmd.value == cmd_unit_pkg::VALUE_FROM_ACC) ? acc_reg : cmd.value;
  wire set_bank_ok = (cmd.bank == cmd_unit_pkg::BANK_OUT);
  wire set_level_ok = (set_src[31:1] == 31'h0);
  wire set_one_ok = set_bank_ok && port_ok && set_level_ok;
  wire set_all_ok = set_bank_ok && all_port;

  // read data selection per bank
  wire [AIN_W-1:0] ain_sel = ANALOG_IN[port*AIN_W +: AIN_W];
  logic [31:0] read_val;
  logic read_ok;
  always_comb
  begin
    read_val = 32'h00000000;
    read_ok = 1'b0;
    if (cmd.bank == cmd_unit_pkg::BANK_DIN && all_port)
    begin
      read_val = {28'h0000000, GP_INPUT};
      read_ok = 1'b1;
    end
    else if (port_ok)
    begin
      unique case (cmd.bank)
        cmd_unit_pkg::BANK_DIN:
        begin
          read_val = {31'h0, GP_INPUT[port]};
          read_ok = 1'b1;
        end
        cmd_unit_pkg::BANK_AIN:
        begin
          read_val = 32'(ain_sel);
          read_ok = 1'b1;
        end
        cmd_unit_pkg::BANK_OUT:
        begin
          read_val = {31'h0, out_reg[port]};
          read_ok = 1'b1;
        end
        default:
        begin
          read_ok = 1'b0;
        end
      endcase
    end
  end

  // status and value of the reply
  logic [7:0] status;
  logic [31:0] rvalue;
  always_comb
  begin
    status = cmd_unit_pkg::STATUS_OK;
    rvalue = 32'h00000000; // don't-care value for start/stop/set
    if (!sum_ok_reg)
      status = cmd_unit_pkg::STATUS_BAD_SUM;
    else if (is_home)
    begin
      if (!axis_ok || cmd.kind > cmd_unit_pkg::HOME_STATUS)
        status = cmd_unit_pkg::STATUS_BAD_TYPE;
      else if (cmd.kind == cmd_unit_pkg::HOME_STATUS)
        rvalue = {31'h0, busy_reg[axis]};
    end
    else if (is_set)
    begin
      if (!(set_one_ok || set_all_ok))
        status = cmd_unit_pkg::STATUS_BAD_VALUE;
    end
    else if (is_read)
    begin
      if (read_ok)
        rvalue = read_val;
      else
        status = cmd_unit_pkg::STATUS_BAD_TYPE;
    end
    else
      status = cmd_unit_pkg::STATUS_BAD_CMD;
  end

  // execute lasts one cycle; every action and the reply image are taken there,
  // so a refused frame never touches outputs, accumulator or busy flags
  wire exec = (state_reg == cmd_unit_pkg::ST_EXEC);
  wire good = exec && (status == cmd_unit_pkg::STATUS_OK);
  wire home_cmd = good && is_home;
  wire start_hit = home_cmd && cmd.kind == cmd_unit_pkg::HOME_START;
  wire stop_hit = home_cmd && cmd.kind == cmd_unit_pkg::HOME_STOP;

  // reply image: host address, target echo, status, code, value msb first
  logic [63:0] reply_word;
  assign reply_word = {cmd_unit_pkg::HOST_ADDR_RST, cmd.target, status, cmd.code, rvalue};

  // state sequence: receive, execute one cycle, send nine bytes
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      cmd_unit_pkg::ST_RECV: if (last_byte) state_next = cmd_unit_pkg::ST_EXEC;
      cmd_unit_pkg::ST_EXEC: state_next = cmd_unit_pkg::ST_SEND;
      cmd_unit_pkg::ST_SEND: if (idx_reg == cmd_unit_pkg::FRAME_LAST) state_next = cmd_unit_pkg::ST_RECV;
      default: state_next = cmd_unit_pkg::ST_RECV;
    endcase
  end

  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      state_reg <= cmd_unit_pkg::ST_RECV;
    else
      state_reg <= state_next;
  end

  // byte index and running checksum; bytes during send are dropped
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      idx_reg <= 4'h0;
      sum_reg <= 8'h00;
      sum_ok_reg <= 1'b0;
    end
    else if (state_reg == cmd_unit_pkg::ST_RECV && RX_VALID)
    begin
      idx_reg <= last_byte ? 4'h0 : idx_reg + 4'h1;
      sum_reg <= last_byte ? 8'h00 : sum_reg + RX_BYTE;
      if (last_byte)
        sum_ok_reg <= sum_match;
    end
    else if (state_reg == cmd_unit_pkg::ST_SEND)
      idx_reg <= (idx_reg == cmd_unit_pkg::FRAME_LAST) ? 4'h0 : idx_reg + 4'h1;
  end

  // frame and reply byte storage, one generate lane per byte
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_bytes
      always_ff @(posedge CLK or negedge NRST)
      begin
        if (!NRST)
        begin
          frame_reg[g] <= 8'h00;
          reply_reg[g] <= 8'h00;
        end
        else
        begin
          if (state_reg == cmd_unit_pkg::ST_RECV && RX_VALID && idx_reg == 4'(g))
            frame_reg[g] <= RX_BYTE;
          if (exec)
            reply_reg[g] <= reply_word[8*(7-g) +: 8];
        end
      end
    end
  endgenerate

  // reply sum is built alongside the outgoing bytes
  wire [7:0] tx_now = reply_reg[idx_reg[2:0]];
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      tx_reg <= '0;
      tx_sum_reg <= 8'h00;
    end
    else if (state_reg == cmd_unit_pkg::ST_SEND)
    begin
      tx_reg.valid <= 1'b1;
      tx_reg.data <= (idx_reg == cmd_unit_pkg::FRAME_LAST) ? tx_sum_reg : tx_now;
      tx_sum_reg <= (idx_reg == cmd_unit_pkg::FRAME_LAST) ? 8'h00 : tx_sum_reg + tx_now;
    end
    else
      tx_reg <= '0;
  end

  // busy flags: a finish in the start cycle does not hide the start
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      busy_reg <= '0;
      start_reg <= '0;
      stop_reg <= '0;
    end
    else
    begin
      start_reg <= start_hit ? (AXES'(1) << axis) : '0;
      stop_reg <= stop_hit ? (AXES'(1) << axis) : '0;
      busy_reg <= (busy_reg & ~HOME_DONE & ~(stop_hit ? (AXES'(1) << axis) : '0)) |
                  (start_hit ? (AXES'(1) << axis) : '0);
    end
  end

  // outputs and accumulator; reads load it when standalone, all-port digital input reads load it always
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      out_reg <= 4'h0;
      acc_reg <= cmd_unit_pkg::ACC_RST;
    end
    else if (good)
    begin
      if (is_set && set_all_ok)
        out_reg <= set_src[3:0];
      else if (is_set)
        out_reg[port] <= set_src[0];
      if (is_read && (STANDALONE || (all_port && cmd.bank == cmd_unit_pkg::BANK_DIN)))
        acc_reg <= read_val;
    end
  end

  // every output comes straight from its flip-flop
  assign TX_VALID = tx_reg.valid;
  assign TX_BYTE = tx_reg.data;
  assign GP_OUTPUT = out_reg;
  assign HOME_START_PULSE = start_reg;
  assign HOME_STOP_PULSE = stop_reg;
  assign HOME_BUSY = busy_reg;
  assign ACCUMULATOR = acc_reg;
endmodule : refsearch_io_command_unit

/* verification/refsearch_io_command_unit_assertions.sv */
// port checker of the command unit
// assumes one clock and an async low reset
`timescale 1ns/100ps
module refsearch_io_command_unit_assertions #(
  parameter int AXES = 6
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [AXES-1:0] HOME_DONE,
  input wire logic TX_VALID,
  input wire logic [7:0] TX_BYTE,
  input wire logic [3:0] GP_OUTPUT,
  input wire logic [AXES-1:0] HOME_START_PULSE,
  input wire logic [AXES-1:0] HOME_STOP_PULSE,
  input wire logic [AXES-1:0] HOME_BUSY,
  input wire logic [31:0] ACCUMULATOR
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // reply burst, and the status and code bytes of a home reply
  sequence s_burst;
    ##1 TX_VALID [*8] ##1 !TX_VALID;
  endsequence
  sequence s_ok_home;
    ##2 TX_BYTE == 8'h64 ##1 TX_BYTE == 8'h0D;
  endsequence
  a_burst_nine: assert property ($rose(TX_VALID) |-> s_burst)
    else $error("reply length");
  a_host_first: assert property ($rose(TX_VALID) |-> TX_BYTE == 8'h02)
    else $error("host byte");
  a_start_reply: assert property ((|HOME_START_PULSE) |=> $rose(TX_VALID) ##0 s_ok_home)
    else $error("start reply");
  a_start_single: assert property ((|HOME_START_PULSE) |=> HOME_START_PULSE == '0)
    else $error("start pulse long");
  a_stop_single: assert property ((|HOME_STOP_PULSE) |=> HOME_STOP_PULSE == '0)
    else $error("stop pulse long");
  a_start_busy: assert property ((|HOME_START_PULSE) |-> (HOME_START_PULSE & ~HOME_BUSY) == '0)
    else $error("start busy");
  a_stop_clear: assert property ((|HOME_STOP_PULSE) |-> ((HOME_STOP_PULSE & HOME_BUSY) == '0) ##1 $rose(TX_VALID))
    else $error("stop busy");
  // done may lose only against a start executed at the same edge
  a_done_clears: assert property ((|HOME_DONE) |=> (HOME_BUSY & $past(HOME_DONE) & ~HOME_START_PULSE) == '0)
    else $error("done busy");
  a_out_at_reply: assert property ($changed(GP_OUTPUT) |=> $rose(TX_VALID))
    else $error("output moved");
  a_acc_at_reply: assert property ($changed(ACCUMULATOR) |=> $rose(TX_VALID))
    else $error("acc moved");
endmodule : refsearch_io_command_unit_assertions
bind refsearch_io_command_unit refsearch_io_command_unit_assertions #(.AXES(AXES)) chk (.CLK(CLK),
  .NRST(NRST), .HOME_DONE(HOME_DONE), .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .GP_OUTPUT(GP_OUTPUT),
  .HOME_START_PULSE(HOME_START_PULSE), .HOME_STOP_PULSE(HOME_STOP_PULSE), .HOME_BUSY(HOME_BUSY),
  .ACCUMULATOR(ACCUMULATOR));

/* verification/host_model.sv */
// host model sending command frames
// assumes send is called only between replies
`timescale 1ns/100ps
module host_model #(
  parameter logic [7:0] TARGET = 8'h01
) (
  input wire logic clk,
  output logic rx_valid = 1'h0,
  output logic [7:0] rx_byte = 8'hA5
);
  // nine bytes, value msb first; bad spoils the sum
  task automatic send(input logic [7:0] c, k, b, input logic [31:0] v, input logic bad);
    logic [7:0] f[9];
    int i;
    f = '{TARGET, c, k, b, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (i = 0; i < 8; i++)
      f[8] = f[8] + f[i];
    f[8] = f[8] + {7'h0, bad};
    for (i = 0; i < 9; i++)
    begin
      @(posedge clk);
      #5;
      rx_valid = 1'h1;
      rx_byte = f[i];
    end
    @(posedge clk);
    #5;
    rx_valid = 1'h0;
    rx_byte = ~f[8]; // released line must not keep the last byte
  endtask : send
endmodule : host_model

/* verification/refsearch_io_command_unit_tb_top.sv */
// self-checking bench of the command unit
// assumes the host model drives the receive side
`timescale 1ns/100ps
`define CHK(n, e, g) begin compares++; if ((e) !== (g)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module refsearch_io_command_unit_tb_top;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic rx_valid, tx_valid;
  logic [7:0] rx_byte, tx_byte, ax;
  logic standalone = 1'h0;
  logic [3:0] gp_input = 4'h0;
  logic [3:0] gp_output;
  logic [3:0] outs = 4'h0;
  logic [63:0] analog_in = 64'h0;
  logic [5:0] home_done = 6'h00;
  logic [5:0] home_busy;
  logic [31:0] accumulator, v;
  logic [31:0] acc = 32'h0;
  logic [8:0] q[$];
  logic [8:0] e;
  logic [7:0] sum = 8'h00;
  int n_errors = 0;
  int compares = 0;
  int seed = 42;
  int idx = 0;
  always #25 clk = ~clk;
  host_model host (.clk(clk), .rx_valid(rx_valid), .rx_byte(rx_byte));
  refsearch_io_command_unit DUT (.CLK(clk), .NRST(nrst), .RX_VALID(rx_valid), .RX_BYTE(rx_byte),
    .STANDALONE(standalone), .GP_INPUT(gp_input), .ANALOG_IN(analog_in), .HOME_DONE(home_done),
    .TX_VALID(tx_valid), .TX_BYTE(tx_byte), .GP_OUTPUT(gp_output), .HOME_START_PULSE(),
    .HOME_STOP_PULSE(), .HOME_BUSY(home_busy), .ACCUMULATOR(accumulator));
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  // note the reply, send the frame, wait for the reply to drain
  task automatic cmd(input logic [7:0] c, k, b, input logic [31:0] val, input logic bad,
    input logic [7:0] st, input logic [31:0] ev, input logic vc);
    int i;
    q.push_back(9'h102);
    q.push_back(9'h101);
    q.push_back({1'h1, st});
    q.push_back({1'h1, c});
    for (i = 3; i >= 0; i--)
      q.push_back({vc, ev[8*i+:8]});
    host.send(c, k, b, val, bad);
    for (i = 0; i < 40 && q.size() != 0; i++)
      @(posedge clk);
    if (q.size() != 0)
    begin
      n_errors++;
      wrap_up();
    end
    repeat (3) @(posedge clk);
    #5;
  endtask : cmd
  // reply watcher: one note per byte, the ninth is the running sum
  always @(negedge clk)
  begin
    if (tx_valid !== 1'h1)
    begin
      idx = 0;
      sum = 8'h00;
    end
    else if (idx == 8)
    begin
      `CHK("sum", sum, tx_byte)
      idx = 9;
    end
    else if (idx < 8)
    begin
      e = q.pop_front();
      if (e[8])
        `CHK("reply", e[7:0], tx_byte)
      sum = sum + tx_byte;
      idx++;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    #5;
    nrst = 1'h1;
    // home: start, poll, finish, poll, restart, stop
    ax = 8'({$random(seed)} % 6);
    cmd(8'h0D, 8'h00, ax, 0, 0, 8'h64, 0, 0);
    `CHK("busy", 1'h1, home_busy[ax])
    cmd(8'h0D, 8'h02, ax, 0, 0, 8'h64, 1, 1);
    home_done[ax] = 1'h1;
    @(posedge clk);
    #5;
    home_done = 6'h00;
    cmd(8'h0D, 8'h02, ax, 0, 0, 8'h64, 0, 1);
    cmd(8'h0D, 8'h00, ax, 0, 0, 8'h64, 0, 0);
    cmd(8'h0D, 8'h01, ax, 0, 0, 8'h64, 0, 0);
    `CHK("busy", 1'h0, home_busy[ax])
    $display("test home done");
    // each output set and read back, then refused frames
    for (int p = 0; p < 4; p++)
    begin
      v = {31'h0, 1'($random(seed))};
      cmd(8'h0E, 8'(p), 8'h02, v, 0, 8'h64, 0, 0);
      outs[p] = v[0];
      `CHK("gp_output", outs, gp_output)
      cmd(8'h0F, 8'(p), 8'h02, 0, 0, 8'h64, v, 1);
    end
    cmd(8'h0E, 8'h04, 8'h02, 1, 0, 8'h04, 0, 0);
    cmd(8'h0E, 8'h00, 8'h02, 2, 0, 8'h04, 0, 0);
    cmd(8'h0E, 8'h00, 8'h02, {31'h0, ~outs[0]}, 1, 8'h01, 0, 0);
    cmd(8'h07, 8'h00, 8'h00, 0, 0, 8'h02, 0, 0);
    `CHK("gp_output", outs, gp_output)
    v = 32'($random(seed)) & 32'hF;
    cmd(8'h0E, 8'hFF, 8'h02, v, 0, 8'h64, 0, 0);
    `CHK("gp_output", v[3:0], gp_output)
    $display("test outputs done");
    // reads in both modes; single-port reads load the accumulator only when standalone
    gp_input = 4'($random(seed));
    analog_in = {$random(seed), $random(seed)};
    for (int p = 0; p < 4; p++)
    begin
      standalone = 1'(p);
      cmd(8'h0F, 8'(p), 8'h00, 0, 0, 8'h64, {31'h0, gp_input[p]}, 1);
      v = {16'h0, analog_in[16*p+:16]};
      cmd(8'h0F, 8'(p), 8'h01, 0, 0, 8'h64, v, 1);
      if (standalone)
        acc = v;
      `CHK("accumulator", acc, accumulator)
    end
    acc = {28'h0, gp_input};
    cmd(8'h0F, 8'hFF, 8'h00, 0, 0, 8'h64, acc, 1);
    `CHK("accumulator", acc, accumulator)
    cmd(8'h0E, 8'hFF, 8'h02, 32'hFFFFFFFF, 0, 8'h64, 0, 0);
    `CHK("gp_output", acc[3:0], gp_output)
    cmd(8'h0F, 8'h02, 8'h02, 0, 0, 8'h64, {31'h0, acc[2]}, 1);
    acc = {31'h0, acc[2]};
    `CHK("accumulator", acc, accumulator)
    cmd(8'h0E, 8'h01, 8'h02, 32'hFFFFFFFF, 0, 8'h64, 0, 0);
    `CHK("gp_output", acc[0], gp_output[1])
    $display("test inputs done");
    wrap_up();
  end
endmodule : refsearch_io_command_unit_tb_top
